//--- src/dd3_mode_dev.sv
/*
 Device-side mode register, init tracking and burst order logic.
 Command pins, CKE and ODT belong to the link clock domain; the
 configuration summary is handed to the system clock by a toggle.
*/
// Functional notes
// [R01] Termination stays off in reset and until CKE is first seen high.
// [R02] Controller holds ODT static during init; low if nominal RTT used.
// [R03] Controller waits tXPR, max of tXS and 5 clocks, before first MRS.
// [R04] Init order is MR2, MR3, MR1 DLL on, MR0 DLL reset, then ZQCL.
// [R05] Bank address selects mode register: 000 MR0 to 011 MR3.
// [R06] MR1 A0 low enables DLL; MR0 A8 high requests DLL reset.
// [R07] Controller waits for both DLL lock and ZQ init before normal use.
// [R08] Only NOP or deselect between init MRS and ZQCL commands.
// [R09] Warm reset: reset low 100 ns, CKE low 10 ns before release.
// [R10] Mode registers undefined after reset; controller writes all four.
// [R11] Each MRS drives every field of the targeted register.
// [R12] Controller keeps tMRD between two MRS commands.
// [R13] Settings take effect within tMOD, except DLL reset.
// [R14] MRS in normal operation only when idle with CKE high.
// [R15] With nominal RTT, ODT low before MRS, high only after tMOD.
// [R16] MR0 write is all of CS, RAS, CAS, WE and BA low.
// [R17] Controller drives BA2, A13 and A14 zero in MR0.
// [R18] Write recovery field at least tWR over tCK, rounded up.
// [R19] MR0 A3 picks sequential or interleaved order.
// [R20] MR0 A1:A0 picks BC4, BL8 or on-the-fly via A12.
// [R21] Burst-8 read order from start column, sequential or XOR.
// [R22] Chop read tristates last four beats; writes use fixed order.
// [R23] Controller waits 500 us after reset release before CKE high; the bench waits 40 link cycles and 5 NOPs.
// [R24] Clock stable and NOP registered before CKE rises.
// [R25] CKE stays high until init completes.
`timescale 1ns/10ps
`default_nettype none
module dd3_mode_dev #(
    parameter int DLLK = dd3_pkg::DLLK_CYC,
    parameter int ZQINIT = dd3_pkg::ZQINIT_CYC
) (
    input wire logic i_clk_sys, // System clock
    input wire logic i_rst_b, // Reset pin, async, active low
    input wire logic i_clk_link, // Memory clock from controller
    input wire logic i_cke, // Clock enable pin
    input wire logic i_odt, // Termination request pin
    input wire dd3_pkg::dd3_cmd_t i_cmd, // Command and address pins
    output logic o_rtt_on, // Termination active, link domain
    output logic o_beat_vld, // Beat carries data, link domain
    output logic [2:0] o_beat_col, // Column of current beat
    output logic o_beat_wr, // Beat belongs to a write
    output logic o_dq_oe, // Data and strobe drivers on
    output logic o_seq_err, // Sticky init order violation
    output dd3_pkg::dd3_cfg_t o_cfg // Config summary, system domain
);
    import dd3_pkg::*;

    function automatic logic [2:0] beat_of(input logic [2:0] c,
            input logic [2:0] i, input logic intl, input logic wr,
            input logic chop);
        if (wr) begin
            beat_of = chop ? {c[A_COL2], i[1:0]} : i;
        end else if (intl) begin
            beat_of = c ^ i;
        end else begin
            beat_of = {c[2] ^ i[2], 2'(c[1:0] + i[1:0])};
        end
    endfunction

    // Command decode
    logic is_nop, is_mrs, is_zqcl, is_rd, is_wr;
    assign is_nop = i_cmd.cs_b || (i_cmd.ras_b && i_cmd.cas_b && i_cmd.we_b);
    // [R16] MRS decode
    assign is_mrs = i_cke && !i_cmd.cs_b && !i_cmd.ras_b && !i_cmd.cas_b
        && !i_cmd.we_b;
    assign is_zqcl = i_cke && !i_cmd.cs_b && i_cmd.ras_b && i_cmd.cas_b
        && !i_cmd.we_b && i_cmd.addr[A_ZQ_LONG];
    assign is_rd = i_cke && !i_cmd.cs_b && i_cmd.ras_b && !i_cmd.cas_b
        && i_cmd.we_b;
    assign is_wr = i_cke && !i_cmd.cs_b && i_cmd.ras_b && !i_cmd.cas_b
        && !i_cmd.we_b;

    // Link domain state
    dd3_init_t st, next_st;
    logic cke_seen, next_cke_seen;
    logic [14:0] mr [4];
    logic [14:0] next_mr [4];
    logic [CNT_W-1:0] dllk_cnt, next_dllk_cnt, zq_cnt, next_zq_cnt;
    logic seq_err, next_seq_err;
    dd3_cfg_t cfg_link, next_cfg_link;
    logic tog, next_tog;

    always_comb begin
        next_st = st;
        next_cke_seen = cke_seen | i_cke;
        next_seq_err = seq_err;
        next_dllk_cnt = (dllk_cnt != '0) ? dllk_cnt - 1'b1 : dllk_cnt;
        next_zq_cnt = (zq_cnt != '0) ? zq_cnt - 1'b1 : zq_cnt;
        for (int k = 0; k < 4; k++) begin
            next_mr[k] = mr[k];
        end
        // [R05] Select target register
        if (is_mrs && i_cmd.ba[2] == 1'b0) begin
            next_mr[i_cmd.ba[1:0]] = i_cmd.addr;
        end
        // [R06] DLL reset starts lock wait
        if (is_mrs && i_cmd.ba == BA_MR0 && i_cmd.addr[A_DLL_RST]) begin
            next_dllk_cnt = CNT_W'(DLLK);
        end
        if (is_zqcl) begin
            next_zq_cnt = CNT_W'(ZQINIT);
        end
        // [R04] Track init order
        unique case (st)
            INIT_WAIT_CKE: begin
                if (i_cke) begin
                    next_st = INIT_MR2;
                end
            end
            INIT_MR2, INIT_MR3, INIT_MR1, INIT_MR0: begin
                if (is_mrs) begin
                    if (st == INIT_MR2 && i_cmd.ba == BA_MR2) begin
                        next_st = INIT_MR3;
                    end else if (st == INIT_MR3 && i_cmd.ba == BA_MR3) begin
                        next_st = INIT_MR1;
                    end else if (st == INIT_MR1 && i_cmd.ba == BA_MR1
                            && !i_cmd.addr[A_DLL_DIS]) begin
                        next_st = INIT_MR0;
                    end else if (st == INIT_MR0 && i_cmd.ba == BA_MR0
                            && i_cmd.addr[A_DLL_RST]) begin
                        next_st = INIT_ZQ;
                    end else begin
                        next_seq_err = 1'b1;
                    end
                end else if (!is_nop) begin
                    // [R08] Foreign command in init
                    next_seq_err = 1'b1;
                end
            end
            INIT_ZQ: begin
                if (is_zqcl) begin
                    next_st = INIT_CAL;
                end else if (!is_nop) begin
                    next_seq_err = 1'b1;
                end
            end
            INIT_CAL: begin
                // [R07] Both waits done
                if (dllk_cnt == '0 && zq_cnt == '0 && !is_zqcl) begin
                    next_st = INIT_RDY;
                end
            end
            INIT_RDY: begin
                next_st = INIT_RDY;
            end
        endcase
        // [R13] New settings visible next cycle
        next_cfg_link.ready = (next_st == INIT_RDY) && (next_dllk_cnt == '0);
        next_cfg_link.dll_on = !next_mr[1][A_DLL_DIS];
        next_cfg_link.intl = next_mr[0][A_BT];
        next_cfg_link.bl = next_mr[0][A_BL_HI:A_BL_LO];
        next_tog = tog ^ (next_cfg_link != cfg_link);
    end

    always_ff @(posedge i_clk_link or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st <= INIT_WAIT_CKE;
            cke_seen <= 1'b0;
            seq_err <= 1'b0;
            dllk_cnt <= '0;
            zq_cnt <= '0;
            cfg_link <= '0;
            tog <= 1'b0;
            for (int k = 0; k < 4; k++) begin
                mr[k] <= '0;
            end
        end else begin
            st <= next_st;
            cke_seen <= next_cke_seen;
            seq_err <= next_seq_err;
            dllk_cnt <= next_dllk_cnt;
            zq_cnt <= next_zq_cnt;
            cfg_link <= next_cfg_link;
            tog <= next_tog;
            for (int k = 0; k < 4; k++) begin
                mr[k] <= next_mr[k];
            end
        end
    end

    // Burst engine
    logic b_act, next_b_act, b_wr, next_b_wr, b_chop, next_b_chop;
    logic b_intl, next_b_intl;
    logic [2:0] b_col, next_b_col, b_i, next_b_i;
    logic next_rtt_on, next_beat_vld, next_beat_wr, next_dq_oe;
    logic [2:0] next_beat_col;
    logic cmd_chop;

    // [R20] Chop choice per command
    always_comb begin
        unique case (cfg_link.bl)
            BL_FIX4: cmd_chop = 1'b1;
            BL_OTF: cmd_chop = !i_cmd.addr[A_BC_B];
            default: cmd_chop = 1'b0;
        endcase
    end

    always_comb begin
        next_b_act = b_act && (b_i != 3'(BEATS - 1));
        next_b_i = b_act ? 3'(b_i + 3'h1) : b_i;
        next_b_wr = b_wr;
        next_b_chop = b_chop;
        next_b_intl = b_intl;
        next_b_col = b_col;
        if ((is_rd || is_wr) && cke_seen) begin
            next_b_act = 1'b1;
            next_b_i = '0;
            next_b_wr = is_wr;
            next_b_chop = cmd_chop;
            // [R19] Order type from MR0
            next_b_intl = cfg_link.intl;
            next_b_col = i_cmd.addr[2:0];
        end
        // [R01] Termination gated by CKE history
        next_rtt_on = next_cke_seen && i_odt;
        // [R21] Beat column order
        next_beat_col = beat_of(b_col, b_i, b_intl, b_wr, b_chop);
        // [R22] Chop beats dropped or tristated
        next_beat_vld = b_act && !(b_chop && b_i >= 3'(HALF));
        next_dq_oe = next_beat_vld && !b_wr;
        next_beat_wr = b_act && b_wr;
    end

    always_ff @(posedge i_clk_link or negedge i_rst_b) begin
        if (!i_rst_b) begin
            b_act <= 1'b0;
            b_i <= '0;
            b_wr <= 1'b0;
            b_chop <= 1'b0;
            b_intl <= 1'b0;
            b_col <= '0;
            o_rtt_on <= 1'b0;
            o_beat_col <= '0;
            o_beat_vld <= 1'b0;
            o_dq_oe <= 1'b0;
            o_beat_wr <= 1'b0;
        end else begin
            b_act <= next_b_act;
            b_i <= next_b_i;
            b_wr <= next_b_wr;
            b_chop <= next_b_chop;
            b_intl <= next_b_intl;
            b_col <= next_b_col;
            o_rtt_on <= next_rtt_on;
            o_beat_col <= next_beat_col;
            o_beat_vld <= next_beat_vld;
            o_dq_oe <= next_dq_oe;
            o_beat_wr <= next_beat_wr;
        end
    end
    assign o_seq_err = seq_err;

    // System side: toggle synchroniser, then capture the stable word
    logic tog_s1, tog_s2, tog_s3;
    dd3_cfg_t next_cfg;
    always_comb begin
        next_cfg = (tog_s2 != tog_s3) ? cfg_link : o_cfg;
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
            o_cfg <= '0;
        end else begin
            tog_s1 <= tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
            o_cfg <= next_cfg;
        end
    end

    logic rd8;
    assign rd8 = is_rd && cke_seen && !cmd_chop;

    property p_rtt_off;
        @(posedge i_clk_link) disable iff (!i_rst_b)
        !cke_seen |-> !o_rtt_on;
    endproperty
    a_rtt_off: assert property (p_rtt_off) else $error("rtt on"); // [R01]
    property p_mr2_first;
        @(posedge i_clk_link) disable iff (!i_rst_b)
        st == INIT_MR2 && is_mrs && i_cmd.ba == BA_MR2 |=> st == INIT_MR3;
    endproperty
    a_mr2_first: assert property (p_mr2_first) else $error("order"); // [R04]
    property p_dll_rst;
        @(posedge i_clk_link) disable iff (!i_rst_b)
        is_mrs && i_cmd.ba == BA_MR0 && i_cmd.addr[A_DLL_RST]
            |=> !cfg_link.ready && dllk_cnt == CNT_W'(DLLK);
    endproperty
    a_dll_rst: assert property (p_dll_rst) else $error("dllk"); // [R06]
    property p_mr0_apply;
        @(posedge i_clk_link) disable iff (!i_rst_b)
        is_mrs && i_cmd.ba == BA_MR0
            |=> cfg_link.intl == $past(i_cmd.addr[A_BT]);
    endproperty
    a_mr0_apply: assert property (p_mr0_apply) else $error("mod"); // [R13]
    property p_seq_rd;
        @(posedge i_clk_link) disable iff (!i_rst_b)
        rd8 && !cfg_link.intl && i_cmd.addr[2:0] == 3'h1 |-> ##2
            o_beat_col == 3'h1 ##1 o_beat_col == 3'h2 ##1
            o_beat_col == 3'h3 ##1 o_beat_col == 3'h0 ##1
            o_beat_col == 3'h5;
    endproperty
    a_seq_rd: assert property (p_seq_rd) else $error("seq"); // [R21]
    property p_intl_rd;
        @(posedge i_clk_link) disable iff (!i_rst_b)
        rd8 && cfg_link.intl && i_cmd.addr[2:0] == 3'h1 |-> ##2
            o_beat_col == 3'h1 ##1 o_beat_col == 3'h0 ##1
            o_beat_col == 3'h3;
    endproperty
    a_intl_rd: assert property (p_intl_rd) else $error("intl"); // [R19]
    property p_chop_tri;
        @(posedge i_clk_link) disable iff (!i_rst_b)
        is_rd && cke_seen && cmd_chop |-> ##2 o_dq_oe [*4]
            ##1 !o_dq_oe;
    endproperty
    a_chop_tri: assert property (p_chop_tri) else $error("chop"); // [R22]
    property p_otf;
        @(posedge i_clk_link) disable iff (!i_rst_b)
        (is_rd || is_wr) && cke_seen && cfg_link.bl == BL_OTF
            |=> b_chop == !$past(i_cmd.addr[A_BC_B]);
    endproperty
    a_otf: assert property (p_otf) else $error("otf"); // [R20]
    property p_mrs_dec;
        @(posedge i_clk_link) disable iff (!i_rst_b)
        is_mrs && i_cmd.ba == BA_MR0 |=> mr[0] == $past(i_cmd.addr);
    endproperty
    a_mrs_dec: assert property (p_mrs_dec) else $error("mr0"); // [R16]
endmodule
`default_nettype wire

//--- src/dd3_pkg.sv
/*
 Shared types and constants for the mode register and burst logic of a
 DDR3 memory die. Assumes the command pins are sampled on the link clock.
*/
package dd3_pkg;
    // Mode register select on BA2..BA0
    localparam logic [2:0] BA_MR0 = 3'h0;
    localparam logic [2:0] BA_MR1 = 3'h1;
    localparam logic [2:0] BA_MR2 = 3'h2;
    localparam logic [2:0] BA_MR3 = 3'h3;
    // Address bit positions
    localparam int A_BL_LO = 0;
    localparam int A_BL_HI = 1;
    localparam int A_BT = 3;
    localparam int A_DLL_RST = 8;
    localparam int A_DLL_DIS = 0;
    localparam int A_ZQ_LONG = 10;
    localparam int A_BC_B = 12;
    localparam int A_COL2 = 2;
    // Burst length field codes
    localparam logic [1:0] BL_FIX8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIX4 = 2'h2;
    // Lock and calibration waits, in link clock periods
    localparam int DLLK_CYC = 512;
    localparam int ZQINIT_CYC = 512;
    localparam int CNT_W = 10;
    localparam int BEATS = 8;
    localparam int HALF = 4;

    typedef struct packed {
        logic cs_b;
        logic ras_b;
        logic cas_b;
        logic we_b;
        logic [2:0] ba;
        logic [14:0] addr;
    } dd3_cmd_t;

    typedef struct packed {
        logic ready;
        logic dll_on;
        logic intl;
        logic [1:0] bl;
    } dd3_cfg_t;

    typedef enum {
        INIT_WAIT_CKE,
        INIT_MR2,
        INIT_MR3,
        INIT_MR1,
        INIT_MR0,
        INIT_ZQ,
        INIT_CAL,
        INIT_RDY
    } dd3_init_t;
endpackage

//--- test/dd3_ctl_model.sv
/*
 Behavioural memory controller driving the command pins of the die.
 Assumes a free-running link clock; the bench calls its tasks.
*/
`timescale 1ns/10ps
`default_nettype none
module dd3_ctl_model #(
    parameter int CKE_WAIT = 100000, // Link cycles after reset release
    parameter int TXPR = 8, // Cycles from CKE high to first MRS
    parameter int TMRD = 4, // Cycles between MRS commands
    parameter int TMOD = 12, // Cycles after MRS before other commands
    parameter int TINIT = 600 // Cycles covering lock and calibration
) (
    input wire logic i_clk_link, // Link clock
    output logic o_cke, // Clock enable pin
    output logic o_odt, // Termination request pin
    output var dd3_pkg::dd3_cmd_t o_cmd // Command and address pins
);
    import dd3_pkg::*;

    initial begin
        o_cke = 1'b0;
        o_odt = 1'b0;
        o_cmd = '1;
    end

    // Deselected bus shows no stale value
    task automatic drive(input logic [3:0] op, input logic [2:0] ba,
            input logic [14:0] a);
        @(posedge i_clk_link);
        o_cmd <= {op, ba, a};
        @(posedge i_clk_link);
        o_cmd <= {1'b1, ~op[2:0], ~ba, ~a};
    endtask

    task automatic nop(input int n);
        repeat (n) begin
            @(posedge i_clk_link);
            o_cmd <= {4'h7, ~o_cmd[17:0]};
        end
    endtask

    task automatic mrs(input logic [2:0] ba, input logic [14:0] a,
            input int gap);
        drive(4'h0, ba, a);
        nop(gap);
    endtask

    task automatic rw(input logic wr, input logic a12, input logic [2:0] c);
        drive(wr ? 4'h4 : 4'h5, 3'h0, {2'h0, a12, 9'h000, c});
    endtask

    task automatic cke_low();
        @(posedge i_clk_link);
        o_cke <= 1'b0;
    endtask

    task automatic power_up(input logic odt, input logic bad);
        @(posedge i_clk_link);
        o_odt <= odt;
        repeat (CKE_WAIT) @(posedge i_clk_link);
        nop(5);
        o_cke <= 1'b1;
        nop(TXPR);
        mrs(bad ? BA_MR3 : BA_MR2, 15'h0000, TMRD);
        mrs(bad ? BA_MR2 : BA_MR3, 15'h0000, TMRD);
        mrs(BA_MR1, 15'h0000, TMOD);
        mrs(BA_MR0, 15'h0300, TMOD);
        drive(4'h6, 3'h0, 15'h0400);
        nop(TINIT);
    endtask
endmodule
`default_nettype wire

//--- test/dd3_mode_dev_tb.sv
/*
 Self-checking bench for the mode register and burst order die logic.
 Assumes the controller model in the test folder.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin \
    check_count++; \
    if ((a) !== (b)) begin \
        failures++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
end
module dd3_mode_dev_tb;
    import dd3_pkg::*;
    localparam int LCK = 8;
    localparam int TMOD = 12;
    typedef struct packed {
        logic [1:0] bl;
        logic intl;
        logic a12;
        logic wr;
        logic [2:0] col;
        logic [31:0] cols;
        logic [7:0] vld;
    } dd3_row_t;
    dd3_row_t rows [8] = '{
        '{BL_FIX8, 1'b0, 1'b0, 1'b0, 3'h1, 32'h12305674, 8'hFF},
        '{BL_FIX8, 1'b1, 1'b0, 1'b0, 3'h1, 32'h10325476, 8'hFF},
        '{2'h3, 1'b0, 1'b0, 1'b0, 3'h7, 32'h74563012, 8'hFF},
        '{BL_OTF, 1'b1, 1'b1, 1'b0, 3'h6, 32'h67452301, 8'hFF},
        '{BL_FIX4, 1'b0, 1'b0, 1'b0, 3'h5, 32'h56740000, 8'hF0},
        '{BL_OTF, 1'b1, 1'b0, 1'b0, 3'h3, 32'h32100000, 8'hF0},
        '{BL_FIX4, 1'b0, 1'b0, 1'b1, 3'h6, 32'h45670000, 8'hF0},
        '{BL_FIX8, 1'b1, 1'b0, 1'b1, 3'h5, 32'h01234567, 8'hFF}
    };
    logic clk_sys;
    logic clk_link;
    logic rst_b;
    logic cke;
    logic odt;
    dd3_cmd_t cmd;
    logic rtt_on;
    logic beat_vld;
    logic [2:0] beat_col;
    logic beat_wr;
    logic dq_oe;
    logic seq_err;
    dd3_cfg_t cfg;
    int failures = 0;
    int check_count = 0;

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        clk_link = 1'b0;
        #3.3;
        forever #7.5 clk_link = ~clk_link;
    end

    dd3_mode_dev #(.DLLK(LCK), .ZQINIT(LCK)) DUT (
        .i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_clk_link(clk_link),
        .i_cke(cke), .i_odt(odt), .i_cmd(cmd), .o_rtt_on(rtt_on),
        .o_beat_vld(beat_vld), .o_beat_col(beat_col), .o_beat_wr(beat_wr),
        .o_dq_oe(dq_oe), .o_seq_err(seq_err), .o_cfg(cfg)
    );

    // Shortened power-up wait keeps the run brief
    dd3_ctl_model #(.CKE_WAIT(40), .TMOD(TMOD), .TINIT(40)) u_ctl (
        .i_clk_link(clk_link), .o_cke(cke), .o_odt(odt), .o_cmd(cmd)
    );

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        conclude();
    end

    initial begin
        rst_b = 1'b0;
        repeat (12) @(posedge clk_sys);
        `CHK({cfg, rtt_on, beat_vld, seq_err}, 8'h00)
        rst_b <= 1'b1;
        fork
            u_ctl.power_up(1'b1, 1'b0);
            begin
                repeat (20) @(negedge clk_link);
                `CHK(rtt_on, 1'b0)
            end
        join
        `CHK({cfg.ready, cfg.dll_on, seq_err, rtt_on}, 4'hD)
        $display("init done");
        foreach (rows[r]) begin
            u_ctl.mrs(BA_MR0, {11'h040, rows[r].intl, 1'b0, rows[r].bl}, TMOD);
            `CHK(cfg.bl, rows[r].bl)
            `CHK(cfg.intl, rows[r].intl)
            u_ctl.rw(rows[r].wr, rows[r].a12, rows[r].col);
            repeat (1) @(posedge clk_link);
            for (int i = 0; i < BEATS; i++) begin
                @(negedge clk_link);
                `CHK(beat_vld, rows[r].vld[7-i])
                `CHK(dq_oe, rows[r].vld[7-i] & ~rows[r].wr)
                if (rows[r].vld[7-i]) begin
                    `CHK(beat_col, rows[r].cols[4*(7-i) +: 3])
                    `CHK(beat_wr, rows[r].wr)
                end
            end
            $display("burst row %0d done", r);
        end
        u_ctl.mrs(3'h4, 15'h0002, TMOD);
        `CHK({cfg.intl, cfg.bl}, 3'h4)
        $display("reserved bank select done");
        u_ctl.cke_low();
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (12) @(posedge clk_sys);
        `CHK({cfg, rtt_on, beat_vld, seq_err}, 8'h00)
        rst_b <= 1'b1;
        u_ctl.power_up(1'b1, 1'b1);
        `CHK(seq_err, 1'b1)
        $display("warm reset with bad order done");
        conclude();
    end
endmodule
`undef CHK
`default_nettype wire
